// [logic/tcc_pkg.sv]
// shared constants and carriers for the timer/counter channel core
package tcc_pkg;
  localparam int CNT_W      = 16;
  localparam int NUM_CH     = 3;
  localparam int NUM_BLK    = 2;
  localparam int NUM_CH_TOT = NUM_BLK * NUM_CH;
  localparam int BMR_W      = 6; // block mode bits per block, upper three spare
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // clock selection codes, 0..4 internal, 5..7 external selections
  localparam logic [2:0] SEL_DIV2  = 3'h0;
  localparam logic [2:0] SEL_DIV8  = 3'h1;
  localparam logic [2:0] SEL_DIV32 = 3'h2;
  localparam logic [2:0] SEL_DIV128 = 3'h3;
  localparam logic [2:0] SEL_SLOW  = 3'h4;
  localparam logic [2:0] SEL_XC0   = 3'h5;
  localparam logic [2:0] SEL_XC1   = 3'h6;
  localparam logic [2:0] SEL_XC2   = 3'h7;
  // prescaler taps into a free running 7-bit divider
  localparam int TAP_DIV2   = 0;
  localparam int TAP_DIV8   = 2;
  localparam int TAP_DIV32  = 4;
  localparam int TAP_DIV128 = 6;
  localparam int PRE_W      = 7;

  // per-channel configuration
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       wave_mode;     // 0 capture, 1 waveform
    logic       io_second_out; // waveform: drive second io
    logic       irq_ovf_en;
    logic       irq_trg_en;
  } tcc_ch_cfg_t;

  // per-channel commands, one-cycle pulses
  typedef struct packed {
    logic clk_enable;
    logic clk_disable;
    logic software_trigger_cmd;
    logic status_read;
  } tcc_ch_cmd_t;

  // per-channel status
  typedef struct packed {
    logic [15:0] counter_value_reg;
    logic        counter_overflow_flag;
    logic        trigger_flag;
    logic        clk_enabled;
    logic        clk_running;
  } tcc_ch_sts_t;
endpackage : tcc_pkg

// [logic/tcc_core.sv]
// two blocks of three 16-bit timer/counter channels
// Operation
// - two blocks of three 16-bit counters
// - three external, five internal clocks, two ios
// - per-channel interrupt, software selects conditions
// - block control write starts three channels
// - block mode routes external clocks, chaining
// - blocks independent, each own registers
// - first io input capture, output waveform
// - second io input capture, selectable waveform
// - clock pins map one per channel
// - counter increments on selected clock rise
// - wrap to zero sets overflow flag
// - counter value readable live
// - trigger zeroes counter on next edge
// - pins reach timer only after handover
// - sync acts as software trigger
// - five internal plus three external sources
// - trigger resets and starts enabled clock
// - overflow sticky until status read
`timescale 1ns/1ps
`default_nettype none
module tcc_core
(
  input  wire logic                                          sys_clk_i,
  input  wire logic                                          rst_i,
  input  wire logic                                          slow_clock_i,
  input  wire logic [tcc_pkg::NUM_BLK-1:0]                   pin_handover_i,
  input  wire logic [tcc_pkg::NUM_BLK-1:0]                   block_control_sync_i,
  input  wire logic [tcc_pkg::NUM_BLK*tcc_pkg::BMR_W-1:0]    block_mode_reg_i,
  input  wire logic [tcc_pkg::NUM_CH_TOT-1:0]                block_clock_pin_i,
  input  wire tcc_pkg::tcc_ch_cfg_t [tcc_pkg::NUM_CH_TOT-1:0] ch_cfg_i,
  input  wire tcc_pkg::tcc_ch_cmd_t [tcc_pkg::NUM_CH_TOT-1:0] ch_cmd_i,
  input  wire logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_first_i,
  input  wire logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_second_i,
  output var  tcc_pkg::tcc_ch_sts_t [tcc_pkg::NUM_CH_TOT-1:0] ch_sts_o,
  output var  logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_first_o,
  output var  logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_first_oe_o,
  output var  logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_second_o,
  output var  logic [tcc_pkg::NUM_CH_TOT-1:0]                channel_io_second_oe_o,
  output var  logic [tcc_pkg::NUM_CH_TOT-1:0]                irq_o
);
  import tcc_pkg::*;
  localparam int NCH = NUM_BLK * NUM_CH;

  // free running master clock prescaler
  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] next_prescale;
  assign next_prescale = prescale + 7'h01;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      prescale <= '0;
    else
      prescale <= next_prescale;
  end

  // pin and slow clock synchronisers; second stage is the only reader of the first
  logic [NCH-1:0] pin_s1, pin_s2;
  logic [NCH-1:0] iof_s1, iof_s2;
  logic [NCH-1:0] ios_s1, ios_s2;
  logic           slow_s1, slow_s2;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      iof_s1  <= '0;
      iof_s2  <= '0;
      ios_s1  <= '0;
      ios_s2  <= '0;
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
    end
    else
    begin
      pin_s1  <= block_clock_pin_i;
      pin_s2  <= pin_s1;
      iof_s1  <= channel_io_first_i;
      iof_s2  <= iof_s1;
      ios_s1  <= channel_io_second_i;
      ios_s2  <= ios_s1;
      slow_s1 <= slow_clock_i;
      slow_s2 <= slow_s1;
    end
  end

  // current level of each channel's first io, as driven or as received
  logic [NCH-1:0] io_first_level;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      localparam int BLK = g / NUM_CH;
      localparam int CH  = g % NUM_CH;
      logic        owned;
      logic        xc;
      logic        clk_lvl;
      logic        clk_prev;
      logic        clk_rise;
      logic        trig;
      logic        trig_pend;
      logic        clk_en;
      logic        clk_run;
      logic [15:0] count;
      logic        ovf;
      logic        trg_flag;
      logic        io_first;
      logic        bmode;

      assign owned = pin_handover_i[BLK];
      // block mode bit per channel: 0 own clock pin, 1 chained from a sibling's first io
      assign bmode = block_mode_reg_i[BLK*BMR_W + CH];
      always_comb
      begin
        xc = 1'b0;
        if (bmode)
          xc = io_first_level[BLK*NUM_CH + ((CH + NUM_CH - 1) % NUM_CH)];
        else
          xc = owned & pin_s2[g];
      end

      // clock source mux
      always_comb
      begin
        unique case (ch_cfg_i[g].clk_sel)
          SEL_DIV2:   clk_lvl = prescale[TAP_DIV2];
          SEL_DIV8:   clk_lvl = prescale[TAP_DIV8];
          SEL_DIV32:  clk_lvl = prescale[TAP_DIV32];
          SEL_DIV128: clk_lvl = prescale[TAP_DIV128];
          SEL_SLOW:   clk_lvl = slow_s2;
          SEL_XC0:    clk_lvl = xc;
          SEL_XC1:    clk_lvl = owned & iof_s2[g];
          SEL_XC2:    clk_lvl = owned & ios_s2[g];
        endcase
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          clk_prev <= 1'b0;
        else
          clk_prev <= clk_lvl;
      end
      assign clk_rise = clk_lvl & ~clk_prev;

      // software trigger or block sync, identical effect
      assign trig = ch_cmd_i[g].software_trigger_cmd | block_control_sync_i[BLK];

      // clock enable and start/stop; start only counts while enabled
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          clk_en  <= 1'b0;
          clk_run <= 1'b0;
        end
        else
        begin
          if (ch_cmd_i[g].clk_disable)
            clk_en <= 1'b0;
          else if (ch_cmd_i[g].clk_enable)
            clk_en <= 1'b1;
          if (ch_cmd_i[g].clk_disable)
            clk_run <= 1'b0;
          else if (trig && (clk_en || ch_cmd_i[g].clk_enable))
            clk_run <= 1'b1;
        end
      end

      // reset pends until the next valid edge
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          trig_pend <= 1'b0;
        else if (trig)
          trig_pend <= 1'b1;
        else if (clk_rise && clk_en && clk_run)
          trig_pend <= 1'b0;
      end

      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          count <= CNT_ZERO;
        else if (clk_rise && clk_en && clk_run)
        begin
          if (trig_pend)
            count <= CNT_ZERO;
          else
            count <= count + 16'h0001;
        end
      end

      // sticky flags, a new event wins over the read clear
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          ovf      <= 1'b0;
          trg_flag <= 1'b0;
        end
        else
        begin
          if (clk_rise && clk_en && clk_run && !trig_pend && count == CNT_MAX)
            ovf <= 1'b1;
          else if (ch_cmd_i[g].status_read)
            ovf <= 1'b0;
          if (trig)
            trg_flag <= 1'b1;
          else if (ch_cmd_i[g].status_read)
            trg_flag <= 1'b0;
        end
      end

      // waveform output toggles on each valid edge taken at count max, even one that a pending trigger turns into a zeroing; simple square wave source for chaining
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          io_first <= 1'b0;
        else if (!ch_cfg_i[g].wave_mode)
          io_first <= 1'b0;
        else if (clk_rise && clk_en && clk_run && count == CNT_MAX)
          io_first <= ~io_first;
      end
      assign io_first_level[g] = ch_cfg_i[g].wave_mode ? io_first : (owned & iof_s2[g]);

      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          channel_io_first_o[g]     <= 1'b0;
          channel_io_first_oe_o[g]  <= 1'b0;
          channel_io_second_o[g]    <= 1'b0;
          channel_io_second_oe_o[g] <= 1'b0;
          irq_o[g]                  <= 1'b0;
          ch_sts_o[g]               <= '0;
        end
        else
        begin
          channel_io_first_o[g]     <= io_first;
          channel_io_first_oe_o[g]  <= owned & ch_cfg_i[g].wave_mode;
          channel_io_second_o[g]    <= count[CNT_W-1];
          channel_io_second_oe_o[g] <= owned & ch_cfg_i[g].wave_mode
                                       & ch_cfg_i[g].io_second_out;
          irq_o[g] <= (ovf & ch_cfg_i[g].irq_ovf_en)
                      | (trg_flag & ch_cfg_i[g].irq_trg_en);
          ch_sts_o[g].counter_value_reg     <= count;
          ch_sts_o[g].counter_overflow_flag <= ovf;
          ch_sts_o[g].trigger_flag          <= trg_flag;
          ch_sts_o[g].clk_enabled           <= clk_en;
          ch_sts_o[g].clk_running           <= clk_run;
        end
      end
    end
  endgenerate
endmodule // tcc_core
`default_nettype wire

// [bench/tcc_chk.sv]
// assertion checker for channel 0 and block 0 of the timer/counter core
`timescale 1ns/1ps
`default_nettype none
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire logic [1:0]                 pin_handover_i,
  input wire logic [1:0]                 block_control_sync_i,
  input wire tcc_pkg::tcc_ch_cfg_t [5:0] ch_cfg_i,
  input wire tcc_pkg::tcc_ch_cmd_t [5:0] ch_cmd_i,
  input wire tcc_pkg::tcc_ch_sts_t [5:0] ch_sts_o,
  input wire logic [5:0]                 channel_io_first_oe_o,
  input wire logic [5:0]                 irq_o
);
  logic [15:0] cv;
  logic        ovf, trg, rd;
  assign cv = ch_sts_o[0].counter_value_reg;
  assign ovf = ch_sts_o[0].counter_overflow_flag;
  assign trg = ch_sts_o[0].trigger_flag;
  assign rd = ch_cmd_i[0].status_read;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_STEP: assert property (
    $changed(cv) && cv != CNT_ZERO |-> cv == $past(cv) + 16'h1) else $error("count step");
  AST_WRAP: assert property (
    $past(cv) == CNT_MAX && cv == CNT_ZERO |-> ##[0:1] (ovf || trg)) else $error("wrap flag");
  AST_HOLD: assert property (
    $fell(ovf) |-> $past(rd) || $past(rd, 2) || $past(rd, 3)) else $error("flag lost");
  AST_READ: assert property (
    rd |-> ##[1:3] (!ovf || cv == CNT_ZERO)) else $error("flag kept after read");
  AST_TRIG: assert property (
    ch_cmd_i[0].software_trigger_cmd || block_control_sync_i[0] |-> ##[1:3] trg)
    else $error("trigger not seen");
  AST_GATE: assert property (
    !ch_sts_o[0].clk_enabled |-> !ch_sts_o[0].clk_running) else $error("runs disabled");
  AST_DIS: assert property (
    ch_cmd_i[0].clk_disable |-> ##[1:3] !ch_sts_o[0].clk_enabled) else $error("not disabled");
  AST_IRQ: assert property (
    (!ovf && !trg) [*3] |-> !$past(irq_o[0])) else $error("interrupt without flag");
  AST_PINS: assert property (
    (!ch_cfg_i[0].wave_mode || !pin_handover_i[0]) [*3] |-> !channel_io_first_oe_o[0])
    else $error("io driven");
endmodule // tcc_chk
bind tcc_core tcc_chk tcc_chk_i (
  .sys_clk_i            (sys_clk_i),
  .rst_i                (rst_i),
  .pin_handover_i       (pin_handover_i),
  .block_control_sync_i (block_control_sync_i),
  .ch_cfg_i             (ch_cfg_i),
  .ch_cmd_i             (ch_cmd_i),
  .ch_sts_o             (ch_sts_o),
  .channel_io_first_oe_o(channel_io_first_oe_o),
  .irq_o                (irq_o)
);
`default_nettype wire

// [bench/tcc_far_end.sv]
// far-side model: channel clock pins, io inputs and the slow clock
`timescale 1ns/1ps
`default_nettype none
module tcc_far_end (
  input  wire logic [5:0] first_oe_i,
  input  wire logic [5:0] first_val_i,
  input  wire logic [5:0] second_oe_i,
  input  wire logic [5:0] second_val_i,
  input  wire logic       sys_clk_i,
  input  wire logic       run_i,
  output logic      [5:0] pin_o,
  output logic      [5:0] first_o,
  output logic      [5:0] second_o,
  output logic            slow_o
);
  logic [3:0] free_cnt = 4'h0;
  logic [2:0] ext_cnt = 3'h0;
  // external clock levels last four cycles, well above the sync limit
  always @(posedge sys_clk_i)
  begin
    free_cnt <= free_cnt + 4'h1;
    ext_cnt <= ext_cnt + {2'b00, run_i};
  end
  assign slow_o = free_cnt[3];
  assign pin_o = {6{ext_cnt[2]}};
  // a channel that drives its io wins the wire
  assign first_o = first_oe_i & first_val_i | ~first_oe_i & pin_o;
  assign second_o = second_oe_i & second_val_i | ~second_oe_i & pin_o;
endmodule // tcc_far_end
`default_nettype wire

// [bench/tb_tcc_core.sv]
// self-checking bench for the timer/counter channel core
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_core;
  import tcc_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              run = 1'b0;
  logic              slow_clock_i;
  logic [1:0]        pin_handover_i = 2'h0;
  logic [1:0]        block_control_sync_i = 2'h0;
  logic [11:0]       block_mode_reg_i = 12'h000;
  logic [5:0]        block_clock_pin_i, channel_io_first_i, channel_io_second_i, irq_o;
  logic [5:0]        channel_io_first_o, channel_io_first_oe_o;
  logic [5:0]        channel_io_second_o, channel_io_second_oe_o;
  tcc_ch_cfg_t [5:0] ch_cfg_i = '0;
  tcc_ch_cmd_t [5:0] ch_cmd_i = '0;
  tcc_ch_sts_t [5:0] ch_sts_o;
  logic [31:0]       lfsr_q = 32'hb3cb;
  logic [31:0]       exp_v, cv_v;
  int                failures = 0;
  int                checks_done = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  tcc_core tcc_core_i (
    .sys_clk_i             (sys_clk_i),
    .rst_i                 (rst_i),
    .slow_clock_i          (slow_clock_i),
    .pin_handover_i        (pin_handover_i),
    .block_control_sync_i  (block_control_sync_i),
    .block_mode_reg_i      (block_mode_reg_i),
    .block_clock_pin_i     (block_clock_pin_i),
    .ch_cfg_i              (ch_cfg_i),
    .ch_cmd_i              (ch_cmd_i),
    .channel_io_first_i    (channel_io_first_i),
    .channel_io_second_i   (channel_io_second_i),
    .ch_sts_o              (ch_sts_o),
    .channel_io_first_o    (channel_io_first_o),
    .channel_io_first_oe_o (channel_io_first_oe_o),
    .channel_io_second_o   (channel_io_second_o),
    .channel_io_second_oe_o(channel_io_second_oe_o),
    .irq_o                 (irq_o)
  );
  tcc_far_end tcc_far_end_i (
    .sys_clk_i   (sys_clk_i),
    .run_i       (run),
    .first_oe_i  (channel_io_first_oe_o),
    .first_val_i (channel_io_first_o),
    .second_oe_i (channel_io_second_oe_o),
    .second_val_i(channel_io_second_o),
    .pin_o       (block_clock_pin_i),
    .first_o     (channel_io_first_i),
    .second_o    (channel_io_second_i),
    .slow_o      (slow_clock_i)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int period(input logic [2:0] sel);
    return sel > SEL_SLOW ? 8 : sel == SEL_SLOW ? 16 : 2 << (2 * sel);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // field order: enable, disable, trigger, read; outputs settle two edges later
  task automatic pulse(input logic [3:0] v, input logic [5:0] m);
    cycles(1);
    for (int i = 0; i < 6; i++)
      ch_cmd_i[i] = m[i] ? v : 4'h0;
    cycles(1);
    ch_cmd_i = '0;
    cycles(2);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    cycles(3);
    rst_i = 1'b0;
    pin_handover_i = 2'h3;
    run = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      lfsr_q = lfsr(lfsr_q);
      block_mode_reg_i = lfsr_q[11:0];
      for (int i = 0; i < 6; i++)
        ch_cfg_i[i].clk_sel = 3'(p * 6 + i);
      pulse(4'h8, 6'h3f); // clock enabled before any trigger
      pulse(4'h2, 6'h3f);
      cycles(1300);
      for (int i = 0; i < 6; i++)
      begin
        exp_v = 32'(1300 / period(ch_cfg_i[i].clk_sel));
        cv_v = 32'(ch_sts_o[i].counter_value_reg);
        check(cv_v + 4 >= exp_v && cv_v <= exp_v + 1 ? exp_v : cv_v, exp_v, "count");
      end
    end
    pulse(4'h1, 6'h3f);
    block_control_sync_i = 2'h1;
    cycles(1);
    block_control_sync_i = 2'h0;
    cycles(3);
    for (int i = 0; i < 6; i++)
      check(ch_sts_o[i].trigger_flag, i < 3, "sync flag");
    pulse(4'hc, 6'h01);
    pulse(4'h2, 6'h01);
    exp_v = 32'(ch_sts_o[0].counter_value_reg);
    cycles(20);
    check(ch_sts_o[0].clk_enabled, 1'b0, "enabled");
    check(ch_sts_o[0].counter_value_reg, exp_v, "held count");
    lfsr_q = lfsr(lfsr_q);
    for (int i = 0; i < 6; i++)
      ch_cfg_i[i].irq_trg_en = lfsr_q[i];
    pulse(4'h1, 6'h3f);
    pulse(4'h2, 6'h3f);
    check(irq_o, lfsr_q[5:0], "interrupts");
    pulse(4'h1, 6'h3f);
    check(irq_o, 6'h00, "interrupts after read");
    for (int i = 0; i < 6; i++)
      ch_cfg_i[i] = {SEL_DIV2, 1'b1, i == 1, 2'h0};
    pin_handover_i = 2'h1;
    cycles(4);
    check(channel_io_first_oe_o, 6'h07, "first io enables");
    check(channel_io_second_oe_o, 6'h02, "second io enables");
    pulse(4'h8, 6'h3f);
    pulse(4'h2, 6'h3f);
    pulse(4'h1, 6'h3f);
    // half way through the wrap the count msb is high on every channel
    cycles(66000);
    check(channel_io_second_o, 6'h3f, "second io msb");
    for (int k = 0; k < 66000 && ch_sts_o[0].counter_overflow_flag !== 1'b1; k++)
      cycles(1);
    cycles(2);
    for (int i = 0; i < 6; i++)
      check(ch_sts_o[i].counter_overflow_flag, 1'b1, "overflow");
    check(channel_io_first_o, 6'h3f, "first io toggled");
    pulse(4'h1, 6'h3f);
    check(ch_sts_o[0].counter_overflow_flag, 1'b0, "overflow after read");
    complete_run;
  end
  initial
  begin
    cycles(150000);
    failures++;
    complete_run;
  end
endmodule // tb_tcc_core
`default_nettype wire
